// ==== pkg/ppjm_pkg.sv ====
// Shared constants and types of the paper-path jam monitor.
// Assumes one 250 MHz engine clock; every jam time counts 1 ms ticks.
package ppjm_pkg;

  // ****************************************
  // Timebase
  // ****************************************
  localparam int unsigned CLK_MHZ  = 250;
  localparam int unsigned TICK_US  = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;

  // ****************************************
  // Timeouts in ms (one tick each)
  // ****************************************
  localparam int unsigned MS_W           = 12;
  localparam logic [11:0] PICK_UPPER_MS  = 12'h5DC;  // 1.5 s
  localparam logic [11:0] PICK_LOWER_MS  = 12'hAF0;  // 2.8 s
  localparam logic [11:0] PICK_LAST_MS   = 12'h44C;  // 1.1 s
  localparam logic [11:0] PAGE_PASS_MS   = 12'h3E8;  // expected sheet time at TOP
  localparam logic [11:0] TOP_STAT_MS    = 12'h190;  // 0.4 s beyond that
  localparam logic [11:0] FUSER_DLY_MS   = 12'h5DC;  // 1.5 s
  localparam logic [11:0] FUSER_STAT_MS  = 12'h8FC;  // 2.3 s
  localparam logic [11:0] FUSER_WRAP_MS  = 12'h2BC;  // 0.7 s
  localparam logic [11:0] DELIV1_MS      = 12'hA8C;  // 2.7 s
  localparam logic [11:0] DELIV2_MS      = 12'h384;  // 0.9 s
  localparam logic [11:0] DELIV_STAT_MS  = 12'h320;  // 0.8 s
  localparam logic [11:0] INIT_ROT_MS    = 12'h3E8;
  localparam logic [11:0] AUTO_DELIV_MS  = 12'h7D0;

  // ****************************************
  // Timer channels
  // ****************************************
  localparam int unsigned NCH       = 9;
  localparam int unsigned CH_ROT    = 0;
  localparam int unsigned CH_PICK   = 1;
  localparam int unsigned CH_TOP    = 2;
  localparam int unsigned CH_FXD    = 3;
  localparam int unsigned CH_FXT    = 4;
  localparam int unsigned CH_WRAP   = 5;
  localparam int unsigned CH_BIN    = 6;
  localparam int unsigned CH_DEL2   = 7;
  localparam int unsigned CH_DSTAT  = 8;

  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] SPD_STOP   = 2'h0;
  localparam logic [1:0] SPD_SLOW   = 2'h1;
  localparam logic [1:0] SPD_NOM    = 2'h2;
  localparam logic [1:0] SPD_FAST   = 2'h3;

  typedef enum logic [3:0] {
    JAM_NONE, JAM_PICK_DELAY, JAM_PICK_STAT, JAM_FUSER_DELAY, JAM_FUSER_STAT,
    JAM_FUSER_WRAP, JAM_DOOR, JAM_RESIDUAL, JAM_DELIV1, JAM_DELIV2, JAM_DELIV_STAT
  } ppjm_jam_e;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_PICK, ST_FEED, ST_AUTODEL, ST_HALT
  } ppjm_state_e;

endpackage

// ==== hw/ppjm_sync.sv ====
// Three-stage input synchroniser for sensor pins.
// Assumes pins are asynchronous; output moves once stages two and three agree.
`timescale 1ns/10ps
module ppjm_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  // Pins and settled levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire  [W-1:0] level_next = (agree & s3_reg) | (~agree & level_out);

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_out <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= level_next;
    end
  end
endmodule // ppjm_sync

// ==== hw/ppjm_timer.sv ====
// Bank of millisecond timeout counters on a shared tick.
// Assumes run_in held high while timing; dropping it clears the channel.
`timescale 1ns/10ps
module ppjm_timer (
  // Clock and reset
  input  wire logic                                          clock_in,
  input  wire logic                                          resetn_in,
  // Timebase and channel control
  input  wire logic                                          tick_in,
  input  wire logic [ppjm_pkg::NCH-1:0]                      run_in,
  input  wire logic [ppjm_pkg::NCH-1:0][ppjm_pkg::MS_W-1:0]  limit_in,
  output logic      [ppjm_pkg::NCH-1:0]                      expired_out
);
  import ppjm_pkg::*;
  logic [NCH-1:0][MS_W-1:0] cnt_reg;

  always_ff @(posedge clock_in) begin
    for (int i = 0; i < NCH; i++) begin
      if (!resetn_in || !run_in[i]) begin
        cnt_reg[i]     <= '0;
        expired_out[i] <= 1'b0;
      end else begin
        // Stops at the limit so it cannot wrap back
        if (tick_in && cnt_reg[i] < limit_in[i])
          cnt_reg[i] <= cnt_reg[i] + 12'h001;
        expired_out[i] <= (cnt_reg[i] >= limit_in[i]);
      end
    end
  end
endmodule // ppjm_timer

// ==== hw/ppjm_monitor.sv ====
// Paper-path supervisor: jam timing, loop control, residual paper, auto delivery.
// Assumes sensor pins asynchronous, formatter commands on the engine clock.
`timescale 1ns/10ps

// How it works
// - Fuser roller speed follows the loop sensor during a feed
// - Full face-down bin is reported to formatter
// - Any jam halts engine and reports its type
// - Pickup retried twice on missed leading edge
// - No edge 1.1 s after retries: pickup delay
// - Top sensor stuck on too long: pickup stationary
// - Fuser exit late after top: fuser delay
// - Fuser exit trailing late: fuser stationary
// - Fuser exit lost paper 0.7 s: wrapping
// - Door, face-up bin, cassette open: door jam
// - Path sensors seeing paper give residual jam
// - Top sensor during initial rotation stops engine
// - Auto delivery command ejects residual sheets
// - Bin sensor late after top: delivery jam 1
// - Delivery jam 1 skipped: full, face-up, duplex
// - Delivery sensor late after fuser exit: jam 2
// - Fuser exit trailing late after top trailing
module ppjm_monitor #(
  parameter int unsigned TICK_CYCLES = ppjm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 resetn_in,
  // Paper sensors (pins)
  input  wire logic                 bin_full_sensor_in,
  input  wire logic                 paper_loop_sensor_in,
  input  wire logic                 top_of_page_sensor_in,
  input  wire logic                 fuser_exit_sensor_in,
  input  wire logic                 delivery_exit_sensor_in,
  input  wire logic                 pre_feed_sensor_in,
  // Door sensors (pins), high when open
  input  wire logic                 cart_door_open_in,
  input  wire logic                 face_up_bin_open_in,
  input  wire logic                 cassette_open_in,
  // Formatter commands
  input  wire logic                 print_start_in,
  input  wire logic                 lower_cassette_in,
  input  wire logic                 face_up_job_in,
  input  wire logic                 duplex_job_in,
  input  wire logic                 auto_delivery_cmd_in,
  // Engine drive
  output logic                      engine_run_out,
  output logic [1:0]                fuser_speed_out,
  output logic                      pickup_strobe_out,
  // Formatter status
  output logic                      ready_out,
  output logic                      bin_full_out,
  output logic                      jam_valid_out,
  output ppjm_pkg::ppjm_jam_e       jam_code_out
);
  import ppjm_pkg::*;

  // ****************************************
  // Sensor synchronisers
  // ****************************************
  logic [8:0] sens_s;

  ppjm_sync #(.W(9)) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .pin_in    ({cassette_open_in, face_up_bin_open_in, cart_door_open_in,
                 pre_feed_sensor_in, delivery_exit_sensor_in, fuser_exit_sensor_in,
                 top_of_page_sensor_in, paper_loop_sensor_in, bin_full_sensor_in}),
    .level_out (sens_s)
  );

  wire bin_s   = sens_s[0];
  wire loop_s  = sens_s[1];
  wire top_s   = sens_s[2];
  wire fx_s    = sens_s[3];
  wire del_s   = sens_s[4];
  wire pre_s   = sens_s[5];
  wire door_s  = |sens_s[8:6];
  wire path_any = loop_s | top_s | fx_s | del_s | pre_s;

  // ****************************************
  // Common 1 ms timebase
  // ****************************************
  logic [31:0] pre_cnt_reg;
  logic        tick_reg;
  wire         pre_wrap = (pre_cnt_reg == TICK_CYCLES - 1);

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      pre_cnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_wrap ? 32'h0000_0000 : pre_cnt_reg + 32'h0000_0001;
      tick_reg    <= pre_wrap;
    end
  end

  // ****************************************
  // Sequencer state and sheet tracking
  // ****************************************
  ppjm_state_e st_reg, st_next;
  ppjm_jam_e   jam_next;
  logic [1:0]  phase_reg, phase_next;
  logic        restart_reg;
  logic        lower_reg;
  logic        bin_chk_reg;
  logic        top_gone_reg;
  logic        fx_seen_reg;
  logic        fx_gone_reg;
  logic        del_seen_reg;
  logic        bin_seen_reg;
  logic        fx_prev_reg;
  logic        door_prev_reg;
  logic [NCH-1:0] exp_w;

  wire in_feed = (st_reg == ST_FEED);
  wire in_pick = (st_reg == ST_PICK);
  wire fx_fall = fx_prev_reg & ~fx_s;
  wire door_closed = door_prev_reg & ~door_s;

  // ****************************************
  // Timeout channels
  // ****************************************
  logic [NCH-1:0]           run_w;
  logic [NCH-1:0][MS_W-1:0] lim_w;

  assign run_w[CH_ROT]   = (st_reg == ST_INIT) | (st_reg == ST_AUTODEL);
  assign run_w[CH_PICK]  = in_pick & ~restart_reg;
  assign run_w[CH_TOP]   = in_feed & top_s & ~top_gone_reg;
  assign run_w[CH_FXD]   = in_feed & ~fx_seen_reg;
  assign run_w[CH_FXT]   = in_feed & ~fx_gone_reg;
  assign run_w[CH_WRAP]  = in_feed & fx_seen_reg & ~fx_s & ~top_gone_reg;
  assign run_w[CH_BIN]   = in_feed & bin_chk_reg & ~bin_seen_reg;
  assign run_w[CH_DEL2]  = in_feed & fx_seen_reg & ~del_seen_reg;
  assign run_w[CH_DSTAT] = in_feed & top_gone_reg & ~fx_gone_reg;

  assign lim_w[CH_ROT]   = (st_reg == ST_INIT) ? INIT_ROT_MS : AUTO_DELIV_MS;
  assign lim_w[CH_PICK]  = (phase_reg == LAST_PHASE) ? PICK_LAST_MS :
                           (lower_reg ? PICK_LOWER_MS : PICK_UPPER_MS);
  assign lim_w[CH_TOP]   = PAGE_PASS_MS + TOP_STAT_MS;
  assign lim_w[CH_FXD]   = FUSER_DLY_MS;
  assign lim_w[CH_FXT]   = FUSER_STAT_MS;
  assign lim_w[CH_WRAP]  = FUSER_WRAP_MS;
  assign lim_w[CH_BIN]   = DELIV1_MS;
  assign lim_w[CH_DEL2]  = DELIV2_MS;
  assign lim_w[CH_DSTAT] = DELIV_STAT_MS;

  ppjm_timer u_timer (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .tick_in     (tick_reg),
    .run_in      (run_w),
    .limit_in    (lim_w),
    .expired_out (exp_w)
  );

  // ****************************************
  // Jam detection, highest priority first
  // ****************************************
  wire pick_miss   = in_pick & exp_w[CH_PICK] & ~restart_reg;
  wire j_pick_dly  = pick_miss & (phase_reg == LAST_PHASE);
  wire j_pick_stat = in_feed & exp_w[CH_TOP];
  wire j_fx_dly    = in_feed & exp_w[CH_FXD];
  wire j_fx_stat   = in_feed & exp_w[CH_FXT];
  wire j_wrap      = in_feed & exp_w[CH_WRAP];
  wire j_del1      = in_feed & exp_w[CH_BIN];
  wire j_del2      = in_feed & exp_w[CH_DEL2];
  wire j_dstat     = in_feed & exp_w[CH_DSTAT];
  // Initial rotation and end of auto delivery both check the path
  wire j_resid     = ((st_reg == ST_INIT) & path_any) |
                     ((st_reg == ST_AUTODEL) & exp_w[CH_ROT] & path_any);

  wire ppjm_jam_e jam_det =
    door_s      ? JAM_DOOR        :
    j_resid     ? JAM_RESIDUAL    :
    j_pick_dly  ? JAM_PICK_DELAY  :
    j_pick_stat ? JAM_PICK_STAT   :
    j_wrap      ? JAM_FUSER_WRAP  :
    j_fx_dly    ? JAM_FUSER_DELAY :
    j_fx_stat   ? JAM_FUSER_STAT  :
    j_dstat     ? JAM_DELIV_STAT  :
    j_del2      ? JAM_DELIV2      :
    j_del1      ? JAM_DELIV1      : JAM_NONE;

  wire sheet_done = fx_gone_reg & top_gone_reg & del_seen_reg &
                    (bin_seen_reg | ~bin_chk_reg);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next    = st_reg;
    jam_next   = jam_code_out;
    phase_next = phase_reg;
    if (jam_det != JAM_NONE && st_reg != ST_HALT) begin
      st_next  = ST_HALT;
      jam_next = jam_det;
    end else begin
      case (st_reg)
        ST_INIT: begin
          if (exp_w[CH_ROT])
            st_next = ST_IDLE;
        end
        ST_IDLE: begin
          if (print_start_in) begin
            st_next    = ST_PICK;
            phase_next = 2'h0;
          end
        end
        ST_PICK: begin
          if (top_s)
            st_next = ST_FEED;
          else if (pick_miss)
            phase_next = phase_reg + 2'h1;
        end
        ST_FEED: begin
          if (sheet_done)
            st_next = ST_IDLE;
        end
        ST_AUTODEL: begin
          if (exp_w[CH_ROT])
            st_next = ST_IDLE;
        end
        ST_HALT: begin
          if (door_s)
            jam_next = JAM_DOOR;
          else if (door_closed) begin
            st_next  = ST_INIT;
            jam_next = JAM_NONE;
          end else if (auto_delivery_cmd_in) begin
            st_next  = ST_AUTODEL;
            jam_next = JAM_NONE;
          end
        end
        default: st_next = ST_INIT;
      endcase
    end
  end

  // Pickup strobe for the first try and the two retries, not the final wait
  wire strobe_next = (st_reg == ST_IDLE && st_next == ST_PICK) ||
                     (pick_miss && phase_reg < 2'h2 && st_next == ST_PICK);
  wire run_next    = (st_next != ST_HALT) && (st_next != ST_IDLE);
  wire [1:0] spd_next = !run_next ? SPD_STOP :
                        (st_next != ST_FEED) ? SPD_NOM :
                        (loop_s ? SPD_FAST : SPD_SLOW);

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      st_reg        <= ST_INIT;
      phase_reg     <= 2'h0;
      restart_reg   <= 1'b0;
      fx_prev_reg   <= 1'b0;
      door_prev_reg <= 1'b0;
    end else begin
      st_reg        <= st_next;
      phase_reg     <= phase_next;
      restart_reg   <= pick_miss;
      fx_prev_reg   <= fx_s;
      door_prev_reg <= door_s;
    end
  end

  // Per-sheet tracking, cleared when a new pickup starts
  always_ff @(posedge clock_in) begin
    if (!resetn_in || st_reg == ST_IDLE) begin
      top_gone_reg <= 1'b0;
      fx_seen_reg  <= 1'b0;
      fx_gone_reg  <= 1'b0;
      del_seen_reg <= 1'b0;
      bin_seen_reg <= 1'b0;
    end else if (in_feed) begin
      top_gone_reg <= top_gone_reg | ~top_s;
      fx_seen_reg  <= fx_seen_reg | fx_s;
      fx_gone_reg  <= fx_gone_reg | (fx_seen_reg & fx_fall);
      del_seen_reg <= del_seen_reg | del_s;
      bin_seen_reg <= bin_seen_reg | bin_s;
    end
  end

  // Job options captured at start of pickup
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      lower_reg   <= 1'b0;
      bin_chk_reg <= 1'b0;
    end else if (st_reg == ST_IDLE && print_start_in) begin
      lower_reg   <= lower_cassette_in;
      bin_chk_reg <= ~(bin_full_out | face_up_job_in | duplex_job_in);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      engine_run_out    <= 1'b0;
      fuser_speed_out   <= SPD_STOP;
      pickup_strobe_out <= 1'b0;
      ready_out         <= 1'b0;
      bin_full_out      <= 1'b0;
      jam_valid_out     <= 1'b0;
      jam_code_out      <= JAM_NONE;
    end else begin
      engine_run_out    <= run_next;
      fuser_speed_out   <= spd_next;
      pickup_strobe_out <= strobe_next;
      ready_out         <= (st_next == ST_IDLE);
      // Sheets pass the same sensor, so the level is held during a feed
      if (!in_feed)
        bin_full_out    <= bin_s;
      jam_valid_out     <= (jam_next != JAM_NONE);
      jam_code_out      <= jam_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_loop_speed_fast: assert property (
    st_reg == ST_FEED && st_next == ST_FEED && loop_s |=> fuser_speed_out == SPD_FAST)
    else $error("fuser roller not sped up on large loop");
  a_bin_full_note: assert property (
    !in_feed && bin_s |=> bin_full_out)
    else $error("bin full not reported");
  a_jam_halts_all: assert property (
    jam_valid_out |-> !engine_run_out && fuser_speed_out == SPD_STOP && !pickup_strobe_out)
    else $error("engine running during jam");
  a_pick_retry_max: assert property (
    in_pick && pick_miss && phase_reg == 2'h2 && !top_s && !door_s
    |=> !pickup_strobe_out && phase_reg == LAST_PHASE)
    else $error("third retry issued");
  a_pick_delay_jam: assert property (
    j_pick_dly && !door_s && !path_any |=> jam_code_out == JAM_PICK_DELAY && st_reg == ST_HALT)
    else $error("pickup delay jam missing");
  a_fuser_wrap_jam: assert property (
    in_feed && exp_w[CH_WRAP] && !door_s && !j_pick_stat |=> jam_code_out == JAM_FUSER_WRAP)
    else $error("fuser wrap jam missing");
  a_door_open_jam: assert property (
    door_s |=> jam_code_out == JAM_DOOR && !engine_run_out)
    else $error("door open not reported");
  a_residual_jam: assert property (
    st_reg == ST_INIT && path_any && !door_s |=> jam_code_out == JAM_RESIDUAL)
    else $error("residual paper not reported");
  a_auto_deliver: assert property (
    st_reg == ST_HALT && auto_delivery_cmd_in && !door_s && !door_closed
    |=> engine_run_out && !jam_valid_out)
    else $error("auto delivery not started");
  a_bin_chk_skip: assert property (
    st_reg == ST_IDLE && print_start_in && (bin_full_out || face_up_job_in || duplex_job_in)
    |=> !bin_chk_reg)
    else $error("delivery jam 1 check not skipped");
  a_jam_latched: assert property (
    jam_valid_out && st_reg == ST_HALT && !door_s && !door_closed && !auto_delivery_cmd_in
    |=> jam_valid_out && $stable(jam_code_out))
    else $error("jam cleared without cause");

  c_sheet_done: cover property (in_feed && sheet_done ##1 ready_out);
  c_pick_retry: cover property (pickup_strobe_out && phase_reg != 2'h0);
  c_auto_deliv: cover property (st_reg == ST_AUTODEL && st_next == ST_IDLE);
  c_door_clear: cover property (door_closed && st_reg == ST_HALT);

endmodule // ppjm_monitor

// ==== sim/ppjm_fmt_model.sv ====
// Formatter model: issues print and automatic delivery commands.
// Assumes the engine clock; commands change on its falling edge.
`timescale 1ns/10ps
module ppjm_fmt_model (
  // Clock and engine status
  input  wire logic clock_in,
  input  wire logic ready_in,
  // Commands to the engine
  output logic      print_start_out,
  output logic      lower_cassette_out,
  output logic      face_up_job_out,
  output logic      duplex_job_out,
  output logic      auto_delivery_out
);
  initial begin
    {print_start_out, lower_cassette_out, face_up_job_out} = 3'h0;
    {duplex_job_out, auto_delivery_out} = 2'h0;
  end

  // One sheet at a time: a print waits for ready, bounded
  task automatic do_print(input logic l, f, x);
    int n;
    n = 0;
    while (ready_in !== 1'h1 && n < 9000) begin
      @(negedge clock_in);
      n++;
    end
    lower_cassette_out = l;
    face_up_job_out = f;
    duplex_job_out = x;
    print_start_out = 1'h1;
    @(negedge clock_in);
    print_start_out = 1'h0;
  endtask

  // Only sent after a residual halt, never unprompted
  task automatic do_auto;
    auto_delivery_out = 1'h1;
    @(negedge clock_in);
    auto_delivery_out = 1'h0;
  endtask
endmodule // ppjm_fmt_model

// ==== sim/tb_top.sv ====
// Testbench: paper-path monitor driven by sensors and a formatter model.
// Assumes TICK_CYCLES of 1, so one millisecond is one clock.
`timescale 1ns/10ps
module tb_top;
  import ppjm_pkg::*;
  // Shrunk tick keeps the whole run near its cycle budget
  localparam int TK = 1;
  logic       clk = 1'h0;
  logic       rn = 1'h0;
  logic       bin = 1'h0;
  logic       lp = 1'h0;
  logic       top = 1'h0;
  logic       fx = 1'h0;
  logic       dl = 1'h0;
  logic       pf = 1'h0;
  logic [2:0] door = 3'h0;
  logic       ps, lc, fu, dx, ad, run, pk, rdy, bf, jv;
  logic       jv_d = 1'h0;
  logic [1:0] spd;
  ppjm_jam_e  code, code_d;
  logic [3:0] exp_q[$];
  int         errors = 0, n_tests = 0, npk = 0, cyc = 0;

  ppjm_monitor #(.TICK_CYCLES(TK)) DUT (
    .clock_in(clk), .resetn_in(rn), .bin_full_sensor_in(bin),
    .paper_loop_sensor_in(lp), .top_of_page_sensor_in(top), .fuser_exit_sensor_in(fx),
    .delivery_exit_sensor_in(dl), .pre_feed_sensor_in(pf), .cart_door_open_in(door[0]),
    .face_up_bin_open_in(door[1]), .cassette_open_in(door[2]), .print_start_in(ps),
    .lower_cassette_in(lc), .face_up_job_in(fu), .duplex_job_in(dx),
    .auto_delivery_cmd_in(ad), .engine_run_out(run), .fuser_speed_out(spd),
    .pickup_strobe_out(pk), .ready_out(rdy), .bin_full_out(bf), .jam_valid_out(jv),
    .jam_code_out(code));
  ppjm_fmt_model FMT (
    .clock_in(clk), .ready_in(rdy), .print_start_out(ps), .lower_cassette_out(lc),
    .face_up_job_out(fu), .duplex_job_out(dx), .auto_delivery_out(ad));

  initial forever #2 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (rdy !== 1'h1 && n < lim * TK) begin
      step(1);
      n++;
    end
    check(rdy, 1'h1);
  endtask
  // Open a door to end any jam; optionally leave paper for a residual halt
  task automatic recover(input int d, input logic res);
    door[d] = 1'h1;
    exp_q.push_back(4'h6);
    step(20);
    {pf, top} = res ? 2'($urandom_range(3, 1)) : 2'h0;
    door[d] = 1'h0;
    if (res) begin
      exp_q.push_back(4'h7);
      step(50 * TK);
      {pf, top} = 2'h0;
      step(10);
      FMT.do_auto();
      step(3);
      check({jv, run}, 2'h1);
    end
    wait_rdy(res ? 2200 : 1100);
    check(exp_q.size(), 0);
  endtask
  // One sheet; sensor times in ms from the top-of-page leading edge
  task automatic path(input logic [3:0] e, input int th, fo, ff, dd, jt,
                      input logic bn, f, x, p);
    int ms;
    bin = p;
    if (e != 4'h0) exp_q.push_back(e);
    step(10);
    if (p) check(bf, 1'h1);
    FMT.do_print(1'h0, f, x);
    step(100 * TK);
    for (ms = 0; ms < 2800 && !(e != 4'h0 && jv === 1'h1); ms++) begin
      top = ms < th;
      fx = ms >= fo && ms < ff;
      dl = ms >= fo + dd && ms < ff + 100;
      if (bn) bin = ms >= fo + 300 && ms < ff + 200;
      if (ms % 50 == 0) lp = 1'($urandom);
      step(TK);
      if (ms % 50 == 10 && ms < 400) check(spd, lp ? 2'h3 : 2'h1);
    end
    {top, fx, dl, bin, lp} = 5'h0;
    if (e != 4'h0) check(ms >= jt - 5 && ms <= jt + 15, 1'h1);
    if (e != 4'h0) recover(e % 3, 1'h0);
    else check(rdy, 1'h1);
    check(exp_q.size(), 0);
    $display("test path done, code %h", e);
  endtask
  task automatic pick(input logic l);
    int t0, tp;
    tp = (l ? 2800 : 1500) * 3 + 1100;
    npk = 0;
    exp_q.push_back(4'h1);
    FMT.do_print(l, 1'h0, 1'h0);
    t0 = cyc;
    while (jv !== 1'h1 && cyc - t0 < (tp + 50) * TK) step(1);
    check(npk, 3);
    check(cyc - t0 >= (tp - 5) * TK && cyc - t0 <= (tp + 15) * TK, 1'h1);
    recover(2, 1'h1);
    $display("test pickup done");
  endtask

  // ****************************************
  // Jam watcher and stimulus
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
    jv_d <= jv;
    code_d <= code;
    if (pk === 1'h1) npk++;
    if (rn === 1'h1 && jv === 1'h1 && (jv_d !== 1'h1 || code !== code_d))
      check({run, spd, code}, {3'h0, exp_q.size() > 0 ? exp_q.pop_front() : 4'h0});
  end

  initial begin
    void'($urandom(46899));
    step(10);
    check({run, rdy, jv, pk}, 4'h0);
    rn = 1'h1;
    step(3);
    check({run, spd}, 3'h6);
    wait_rdy(1100);
    $display("test reset done");
    path(4'h0, 1000, 500, 1300, 200, 0, 1'h1, 1'h0, 1'h0, 1'h0);
    path(4'h8, 1000, 500, 1300, 200, 2700, 1'h0, 1'h0, 1'h0, 1'h0);
    path(4'h0, 1000, 500, 1300, 200, 0, 1'h0, 1'h1, 1'h0, 1'h0);
    path(4'h0, 1000, 500, 1300, 200, 0, 1'h0, 1'h0, 1'h1, 1'h0);
    path(4'h0, 1000, 500, 1300, 200, 0, 1'h0, 1'h0, 1'h0, 1'h1);
    path(4'h2, 2000, 500, 2500, 200, 1400, 1'h1, 1'h0, 1'h0, 1'h0);
    path(4'h3, 1000, 9000, 9000, 200, 1500, 1'h0, 1'h0, 1'h0, 1'h0);
    path(4'h5, 1300, 200, 400, 200, 1100, 1'h1, 1'h0, 1'h0, 1'h0);
    path(4'h9, 1000, 500, 1300, 2000, 1400, 1'h1, 1'h0, 1'h0, 1'h0);
    path(4'hA, 1000, 500, 2000, 200, 1800, 1'h1, 1'h0, 1'h0, 1'h0);
    pick(1'h0);
    pick(1'h1);
    close_out();
  end
endmodule // tb_top
